// File: hdl/wdt_core.sv
// watchdog / interval timer with avalon-mm register slave
`include "wdt_cfg.svh"
module wdt_core
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // chip configuration and status
  input wire logic watchdog_enable_fuse,
  input wire logic other_reset,
  input wire logic cpu_clk_en,
  input wire logic power_down,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // chip side
  output logic chip_reset,
  output logic osc_restart,
  output logic irq
);
  localparam int RstCycles = `WDT_RST_CYCLES;
  localparam int StableCycles = `WDT_OSC_STABLE_CYCLES;

  logic [7:0] ctrl_q;
  logic written_q;
  logic [`WDT_CNT_W-1:0] cnt_q;
  wdt_key_t key_q;
  wdt_rst_t rs_q;
  logic [6:0] rs_cnt_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic ack_q;
  logic tick;
  logic wr_go;
  logic rd_go;
  logic feed_ok;
  logic ovf;
  logic run_eff;
  logic clk_eff;
  logic [`WDT_CNT_W-1:0] limit;

  // timeout length for a select code
  function automatic logic [`WDT_CNT_W-1:0] wdt_limit(input logic [2:0] sel);
    wdt_limit = `WDT_CNT_W'(`WDT_BASE_CLOCKS) << sel;
  endfunction

  // one wait state: request taken on the edge where waitrequest is low
  assign wr_go = avs_write && !avs_waitrequest;
  assign rd_go = avs_read && !avs_waitrequest;
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end
  assign avs_waitrequest = !ack_q;

  assign run_eff = watchdog_enable_fuse | ctrl_q[`WDT_RUN_BIT];
  assign clk_eff = !watchdog_enable_fuse & ctrl_q[`WDT_CLK_BIT];
  assign limit = wdt_limit(ctrl_q[2:0]);
  assign ovf = run_eff && !other_reset && tick && cnt_q == limit - `WDT_CNT_W'(1);
  assign feed_ok = wr_go && avs_address == `WDT_FEED_OFS && key_q == WDT_KEY_ARMED
                   && avs_writedata[7:0] == `WDT_KEY_SECOND;

  // tick source; rc path free-runs, so a stopped cpu clock still times out
  wdt_tick_gen u_tick (
    .clk(clk),
    .rst(rst),
    .use_cpu_div(clk_eff),
    .cpu_clk_en(cpu_clk_en),
    .tick(tick)
  );

  // feed key sequencer; other writes between the keys keep it armed
  always_ff @(posedge clk) begin
    if (rst || other_reset) begin
      key_q <= WDT_KEY_IDLE;
    end else if (wr_go && avs_address == `WDT_FEED_OFS) begin
      unique case (key_q)
        WDT_KEY_IDLE: key_q <= (avs_writedata[7:0] == `WDT_KEY_FIRST) ? WDT_KEY_ARMED
                               : WDT_KEY_IDLE;
        WDT_KEY_ARMED: key_q <= (avs_writedata[7:0] == `WDT_KEY_FIRST) ? WDT_KEY_ARMED
                                : WDT_KEY_IDLE;
        default: key_q <= WDT_KEY_IDLE;
      endcase
    end
  end

  // timeout counter; a bad key leaves the schedule untouched
  always_ff @(posedge clk) begin
    if (rst || other_reset || rs_q != WDT_RS_IDLE) begin
      cnt_q <= '0;
    end else if (feed_ok || ovf) begin
      cnt_q <= '0;
    end else if (run_eff && tick) begin
      cnt_q <= cnt_q + `WDT_CNT_W'(1);
    end
  end

  // control register; overflow set beats a feed clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst || other_reset) begin
      ctrl_q <= watchdog_enable_fuse ? `WDT_CTRL_RST_FUSE : `WDT_CTRL_RST_NOFUSE;
      written_q <= 1'b0;
    end else if (rs_q == WDT_RS_PULSE) begin
      ctrl_q <= `WDT_CTRL_RST_WDOG;
      written_q <= 1'b0;
    end else begin
      if (wr_go && avs_address == `WDT_CTRL_OFS
          && !(watchdog_enable_fuse && written_q)) begin
        ctrl_q <= {2'b00, ctrl_q[`WDT_OVF_BIT], avs_writedata[4:0]};
        written_q <= 1'b1;
      end else if (feed_ok) begin
        ctrl_q[`WDT_OVF_BIT] <= 1'b0;
      end
      if (ovf) begin
        ctrl_q[`WDT_OVF_BIT] <= 1'b1;
      end
    end
  end

  // watchdog reset pulse and oscillator wake sequencing
  always_ff @(posedge clk) begin
    if (rst || other_reset) begin
      rs_q <= WDT_RS_IDLE;
      rs_cnt_q <= 7'h00;
      chip_reset <= 1'b0;
      osc_restart <= 1'b0;
    end else begin
      unique case (rs_q)
        WDT_RS_IDLE: begin
          if (ovf && watchdog_enable_fuse) begin
            rs_q <= power_down ? WDT_RS_WAKE : WDT_RS_PULSE;
            rs_cnt_q <= 7'h00;
            chip_reset <= 1'b1;
            osc_restart <= power_down;
          end
        end
        WDT_RS_WAKE: begin
          rs_cnt_q <= rs_cnt_q + 7'h01;
          if (rs_cnt_q == 7'(StableCycles - 1)) begin
            rs_q <= WDT_RS_PULSE;
            rs_cnt_q <= 7'h00;
            osc_restart <= 1'b0;
          end
        end
        WDT_RS_PULSE: begin
          rs_cnt_q <= rs_cnt_q + 7'h01;
          if (rs_cnt_q == 7'(RstCycles - 1)) begin
            rs_q <= WDT_RS_IDLE;
            chip_reset <= 1'b0;
          end
        end
        default: rs_q <= WDT_RS_IDLE;
      endcase
    end
  end

  // interrupt status: bit0 interval overflow, bit1 bad feed key; read clears
  always_ff @(posedge clk) begin
    if (rst) begin
      stat_q <= 2'h0;
      mask_q <= 2'h0;
    end else begin
      // clear only the bits the read returned; an event caught between the
      // data capture and the accepting edge would otherwise be lost
      stat_q <= (rd_go && avs_address == `WDT_IRQ_STAT_OFS) ? stat_q & ~avs_readdata[1:0]
                                                            : stat_q;
      if (ovf && !watchdog_enable_fuse) begin
        stat_q[0] <= 1'b1;
      end
      if (wr_go && avs_address == `WDT_FEED_OFS && key_q == WDT_KEY_ARMED && !feed_ok) begin
        stat_q[1] <= 1'b1;
      end
      if (wr_go && avs_address == `WDT_IRQ_MASK_OFS) begin
        mask_q <= avs_writedata[1:0];
      end
    end
  end

  // interrupt output and read data register
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      irq <= |(stat_q & mask_q);
      if (avs_read && !ack_q) begin
        unique case (avs_address)
          `WDT_CTRL_OFS: avs_readdata <= {24'h0, ctrl_q[7:5], run_eff, clk_eff,
                                          ctrl_q[2:0]};
          `WDT_IRQ_STAT_OFS: avs_readdata <= {30'h0, stat_q};
          `WDT_IRQ_MASK_OFS: avs_readdata <= {30'h0, mask_q};
          default: avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  // guards
  sequence wdog_fire_s;
    ovf && watchdog_enable_fuse && !power_down && rs_q == WDT_RS_IDLE;
  endsequence
  sequence pulse_s;
    chip_reset [*8] ##1 chip_reset ##1 chip_reset;
  endsequence

  reset_pulse_a: assert property (@(posedge clk) disable iff (rst || other_reset)
    wdog_fire_s |=> pulse_s ##1 !chip_reset) else $error("reset pulse length wrong");
  ovf_flag_set_a: assert property (@(posedge clk) disable iff (rst || other_reset)
    ovf && !watchdog_enable_fuse |=> ctrl_q[`WDT_OVF_BIT]) else $error("overflow flag not set");
  feed_clear_a: assert property (@(posedge clk) disable iff (rst || other_reset)
    feed_ok && !ovf |=> cnt_q == '0 && !ctrl_q[`WDT_OVF_BIT]) else $error("feed did not restart");
  run_forced_a: assert property (@(posedge clk) disable iff (rst)
    watchdog_enable_fuse && rd_go && avs_address == `WDT_CTRL_OFS
    |-> avs_readdata[4:3] == 2'b10) else $error("fuse forcing broken");
  bad_key_a: assert property (@(posedge clk) disable iff (rst || other_reset)
    wr_go && avs_address == `WDT_FEED_OFS && !feed_ok && !ovf && rs_q == WDT_RS_IDLE
    |=> cnt_q == $past(cnt_q) || cnt_q == $past(cnt_q) + `WDT_CNT_W'(1))
    else $error("bad key moved schedule");
  hold_other_a: assert property (@(posedge clk) disable iff (rst)
    other_reset |=> cnt_q == '0 && !chip_reset) else $error("timer active in reset");
  once_write_a: assert property (@(posedge clk) disable iff (rst || other_reset)
    watchdog_enable_fuse && written_q && rs_q == WDT_RS_IDLE && !ovf
    |=> ctrl_q[2:0] == $past(ctrl_q[2:0])) else $error("second write took effect");
  wdog_rst_val_a: assert property (@(posedge clk) disable iff (rst || other_reset)
    rs_q == WDT_RS_PULSE && rs_cnt_q == 7'h00 |=> ctrl_q == `WDT_CTRL_RST_WDOG)
    else $error("watchdog reset value wrong");
  wake_a: assert property (@(posedge clk) disable iff (rst || other_reset)
    ovf && watchdog_enable_fuse && power_down && rs_q == WDT_RS_IDLE
    |=> osc_restart && chip_reset) else $error("no oscillator restart");
  irq_level_a: assert property (@(posedge clk) disable iff (rst)
    |(stat_q & mask_q) |=> irq) else $error("irq not raised");
  irq_quiet_a: assert property (@(posedge clk) disable iff (rst)
    !(|(stat_q & mask_q)) |=> !irq) else $error("irq without status");
  base_len_a: assert property (@(posedge clk) disable iff (rst || other_reset)
    ovf && ctrl_q[2:0] == 3'h0 |-> cnt_q == `WDT_CNT_W'(`WDT_BASE_CLOCKS - 1))
    else $error("base timeout length wrong");
  one_wait_a: assert property (@(posedge clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held too long");
endmodule

// File: common/wdt_cfg.svh
// offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
`define WDT_ADDR_W 8
`define WDT_CTRL_OFS 8'hA7
`define WDT_FEED_OFS 8'hA8
`define WDT_IRQ_STAT_OFS 8'hA9
`define WDT_IRQ_MASK_OFS 8'hAA
`define WDT_OVF_BIT 5
`define WDT_RUN_BIT 4
`define WDT_CLK_BIT 3
`define WDT_CTRL_RST_WDOG 8'h30
`define WDT_CTRL_RST_FUSE 8'h10
`define WDT_CTRL_RST_NOFUSE 8'h00
`define WDT_CTRL_WMASK 8'h3F
`define WDT_KEY_FIRST 8'h1E
`define WDT_KEY_SECOND 8'hE1
`define WDT_BASE_CLOCKS 8192
`define WDT_CNT_W 21
`define WDT_CPU_DIV 6
`define WDT_RC_DIV 4
`define WDT_RST_PULSE_NS 1000
`define WDT_CLK_PERIOD_NS 100
`define WDT_RST_CYCLES ((`WDT_RST_PULSE_NS + `WDT_CLK_PERIOD_NS - 1) / `WDT_CLK_PERIOD_NS)
`define WDT_OSC_STABLE_CYCLES 64
`endif

// File: common/wdt_pkg.sv
// types shared by the watchdog design files
package wdt_pkg;
  typedef enum logic [2:0] {
    WDT_KEY_IDLE = 3'b001,
    WDT_KEY_ARMED = 3'b010,
    WDT_KEY_SPARE = 3'b100
  } wdt_key_t;
  typedef enum logic [2:0] {
    WDT_RS_IDLE = 3'b001,
    WDT_RS_PULSE = 3'b010,
    WDT_RS_WAKE = 3'b100
  } wdt_rst_t;
endpackage

// File: hdl/wdt_tick_gen.sv
// watchdog clock tick generator: rc oscillator stand-in or cpu clock / 6
`include "wdt_cfg.svh"
module wdt_tick_gen
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // selection and stall
  input wire logic use_cpu_div,
  input wire logic cpu_clk_en,
  // output
  output logic tick
);
  logic [2:0] rc_cnt_q;
  logic [2:0] cpu_cnt_q;

  // rc stand-in keeps running even when the cpu clock is stopped
  always_ff @(posedge clk) begin
    if (rst || rc_cnt_q == 3'(`WDT_RC_DIV - 1)) begin
      rc_cnt_q <= 3'h0;
    end else begin
      rc_cnt_q <= rc_cnt_q + 3'h1;
    end
  end

  // cpu divider only advances while the cpu clock runs
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_cnt_q <= 3'h0;
    end else if (cpu_clk_en) begin
      cpu_cnt_q <= (cpu_cnt_q == 3'(`WDT_CPU_DIV - 1)) ? 3'h0 : cpu_cnt_q + 3'h1;
    end
  end

  // one-cycle tick from the chosen source
  always_ff @(posedge clk) begin
    if (rst) begin
      tick <= 1'b0;
    end else if (use_cpu_div) begin
      tick <= cpu_clk_en && cpu_cnt_q == 3'(`WDT_CPU_DIV - 1);
    end else begin
      tick <= rc_cnt_q == 3'(`WDT_RC_DIV - 1);
    end
  end
endmodule

// File: testbench/testbench.sv
// self-checking bench for the watchdog / interval timer core
`include "wdt_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ctl = `WDT_CTRL_OFS;
  localparam logic [7:0] feed = `WDT_FEED_OFS;
  localparam logic [7:0] stat = `WDT_IRQ_STAT_OFS;
  localparam logic [7:0] mask = `WDT_IRQ_MASK_OFS;
  logic clk = 1'h0, rst = 1'h1, fuse = 1'h1, other_reset = 1'h0;
  logic cpu_clk_en = 1'h1, power_down = 1'h0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'h0, avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic avs_waitrequest, chip_reset, osc_restart, irq;
  int error_cnt = 0, n_checks = 0, n;

  // 100 ns clock
  always #50 clk = ~clk;

  wdt_core uut (
    .clk(clk), .rst(rst), .watchdog_enable_fuse(fuse), .other_reset(other_reset),
    .cpu_clk_en(cpu_clk_en), .power_down(power_down), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .chip_reset(chip_reset), .osc_restart(osc_restart), .irq(irq)
  );

  task automatic fail(input string m);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask

  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk);
    // only the watchdog process ends a wait that never finishes
    while (avs_waitrequest !== 1'h0) begin
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask

  task automatic rd8(input logic [7:0] a, input logic [7:0] e, input string m);
    bus(1'h0, a, 8'h00);
    chk(rd, {24'h000000, e}, m);
  endtask

  function automatic logic sig(input int w);
    return w == 0 ? chip_reset : (w == 1 ? osc_restart : irq);
  endfunction

  // edges until an output reaches a level; outputs are flops, so the
  // value read at the edge is the settled one from the cycle before
  task automatic wait_lvl(input int w, input logic v, input int lim);
    n = 0;
    while (sig(w) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic span(input int w, input logic v, input int lo, input int hi, input string m);
    wait_lvl(w, v, hi + 1);
    n_checks++;
    if (n < lo || n > hi) fail($sformatf("%s after %0d cycles", m, n));
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    // watchdog role: reset value, forced bits, one control write only
    rd8(ctl, 8'h10, "ctrl reset fuse set");
    rd8(8'hFF, 8'h00, "unmapped read");
    wr8(feed, `WDT_KEY_FIRST);
    wr8(feed, `WDT_KEY_SECOND);
    wr8(ctl, 8'h08);
    rd8(ctl, 8'h10, "run and clock forced");
    wr8(ctl, 8'h07);
    rd8(ctl, 8'h10, "second ctrl write");
    $display("test fuse_ctrl done");
    // cpu clock stopped; split good feed, then a bad pair that must not restart
    cpu_clk_en <= 1'h0;
    repeat (1000) @(posedge clk);
    wr8(feed, `WDT_KEY_FIRST);
    rd8(ctl, 8'h10, "ctrl between keys");
    wr8(feed, `WDT_KEY_SECOND);
    wr8(feed, `WDT_KEY_FIRST);
    wr8(feed, 8'h55);
    span(0, 1'h1, 32730, 32800, "overflow");
    span(0, 1'h0, `WDT_RST_CYCLES, `WDT_RST_CYCLES, "reset pulse");
    rd8(ctl, 8'h30, "ctrl after overflow");
    wr8(feed, `WDT_KEY_FIRST);
    wr8(feed, `WDT_KEY_SECOND);
    rd8(ctl, 8'h10, "flag cleared by feed");
    cpu_clk_en <= 1'h1;
    $display("test feed done");
    // held chip reset stops the count; later overflow in power-down
    other_reset <= 1'h1;
    repeat (3000) @(posedge clk);
    other_reset <= 1'h0;
    wait_lvl(0, 1'h1, 30000);
    chk(n, 30000, "no overflow after held reset");
    power_down <= 1'h1;
    span(1, 1'h1, 2000, 3000, "oscillator restart");
    span(1, 1'h0, `WDT_OSC_STABLE_CYCLES, `WDT_OSC_STABLE_CYCLES, "osc wait");
    span(0, 1'h0, `WDT_RST_CYCLES, `WDT_RST_CYCLES, "wake reset end");
    power_down <= 1'h0;
    $display("test power_down done");
    // timer role: masking, status clear on read, interval overflow
    fuse <= 1'h0;
    rst <= 1'h1;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd8(ctl, 8'h00, "ctrl reset fuse clear");
    wr8(mask, 8'h00);
    wr8(feed, `WDT_KEY_FIRST);
    wr8(feed, 8'h55);
    repeat (3) @(posedge clk);
    chk(irq, 1'h0, "masked irq");
    wr8(mask, 8'h03);
    span(2, 1'h1, 0, 3, "unmasked irq");
    rd8(stat, 8'h02, "bad key status");
    rd8(stat, 8'h00, "status cleared");
    chk(irq, 1'h0, "irq after clear");
    wr8(ctl, 8'h10);
    span(2, 1'h1, 32700, 32800, "interval overflow");
    chk(chip_reset, 1'h0, "no chip reset");
    rd8(stat, 8'h01, "interval status");
    rd8(ctl, 8'h30, "overflow flag");
    $display("test interval done");
    final_report;
  end

  // cut a hang short well after the longest expected run
  initial begin
    repeat (110000) @(posedge clk);
    fail("watchdog timeout");
    final_report;
  end
endmodule
